// [core/lbh_consts.svh]
// Timing counts, encodings and reset levels for the local bus host interface.
`ifndef LBH_CONSTS_SVH
`define LBH_CONSTS_SVH
`define LBH_CLK_PERIOD_NS 20
`define LBH_RST_MIN_PERIODS 15
`define LBH_HOST_CPU_RESET_OUT_PERIODS 62
`define LBH_HOST_CPU_RESET_OUT_W 6
`define LBH_EDACK_IDLE 3'h4
`define LBH_WAIT_W 4
`define LBH_CYC_W 3
`define LBH_CYC_IOR 3'h2
`define LBH_CYC_IOW 3'h3
`define LBH_CYC_MEMR 3'h6
`define LBH_CYC_MEMW 3'h7
`define LBH_CYC_INTA 3'h0
`define LBH_CYC_HALT_SD 3'h5
`define LBH_LANE_HALT_MASK 4'h7
`define LBH_LANE_HALT_VAL 4'h3
`endif

// [core/lbh_pkg.sv]
// Types shared by both ends of the local bus host interface.
package lbh_pkg;
    // Decoded slave cycle kinds.
    typedef enum logic [2:0] {
        LBH_C_NONE,
        LBH_C_INTA,
        LBH_C_IOR,
        LBH_C_IOW,
        LBH_C_MEMR,
        LBH_C_MEMW,
        LBH_C_HALT,
        LBH_C_SHUTDOWN
    } lbh_cyc_t;

    // Master bus states.
    typedef enum logic [2:0] {
        LBH_S_IDLE,
        LBH_S_T1,
        LBH_S_T2,
        LBH_S_T1P,
        LBH_S_T2P,
        LBH_S_T2I
    } lbh_mst_t;
endpackage

// [core/lbh_bus_if.sv]
// Shared local bus between the peripheral end and the host end.
`timescale 1ns/1ps
interface lbh_bus_if;
    logic [31:0] addr_dev;
    logic addr_dev_oe;
    logic [31:0] addr_host;
    logic addr_host_oe;
    logic [31:0] data_dev;
    logic data_dev_oe;
    logic [31:0] data_host;
    logic data_host_oe;
    logic [3:0] byte_lane_sel_n_dev;
    logic [3:0] byte_lane_sel_n_host;
    logic [2:0] cyc_type_dev;
    logic [2:0] cyc_type_host;
    logic cyc_dev_oe;
    logic cyc_host_oe;
    logic addr_strobe_n_dev;
    logic addr_strobe_n_dev_oe;
    logic addr_strobe_n_host;
    logic addr_strobe_n_host_oe;
    logic cycle_done_n;
    logic next_addr_req_n;
    logic bus_request;
    logic bus_grant_in;
    logic host_cpu_reset_out;
    logic irq_out;
    logic wait_gen_done_n;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] byte_lane_sel_n;
    logic [2:0] cyc_type;
    logic addr_strobe_n;

    // Resolved wire levels; an undriven strobe sits high as with a pull-up.
    assign addr = addr_dev_oe ? addr_dev : (addr_host_oe ? addr_host : 32'h0);
    assign data = data_dev_oe ? data_dev : (data_host_oe ? data_host : 32'h0);
    assign byte_lane_sel_n = addr_dev_oe ? byte_lane_sel_n_dev :
                             (addr_host_oe ? byte_lane_sel_n_host : 4'hF);
    assign cyc_type = cyc_dev_oe ? cyc_type_dev : (cyc_host_oe ? cyc_type_host : 3'h7);
    assign addr_strobe_n = addr_strobe_n_dev_oe ? addr_strobe_n_dev :
                           (addr_strobe_n_host_oe ? addr_strobe_n_host : 1'b1);

    modport dev (
        output addr_dev, addr_dev_oe, data_dev, data_dev_oe, byte_lane_sel_n_dev,
        output cyc_type_dev, cyc_dev_oe, addr_strobe_n_dev, addr_strobe_n_dev_oe,
        output bus_request, host_cpu_reset_out, irq_out, wait_gen_done_n,
        input addr, data, byte_lane_sel_n, cyc_type, addr_strobe_n,
        input cycle_done_n, next_addr_req_n, bus_grant_in
    );
    modport host (
        output addr_host, addr_host_oe, data_host, data_host_oe, byte_lane_sel_n_host,
        output cyc_type_host, cyc_host_oe, addr_strobe_n_host, addr_strobe_n_host_oe,
        output bus_grant_in,
        input addr, data, byte_lane_sel_n, cyc_type, addr_strobe_n,
        input cycle_done_n, bus_request, host_cpu_reset_out, irq_out
    );
endinterface

// [core/lbh_dev_end.sv]
// Peripheral end of the local bus host interface: slave decode, master sequencing, resets.
`timescale 1ns/1ps
`include "lbh_consts.svh"

module lbh_dev_end
    import lbh_pkg::*;
#(
    parameter int WAIT_W = `LBH_WAIT_W
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    lbh_bus_if.dev bus,
    input wire logic dma_req_i,
    input wire logic [31:0] dma_addr_i,
    input wire logic [3:0] dma_lanes_n_i,
    input wire logic [2:0] dma_cyc_i,
    input wire logic [31:0] dma_wdata_i,
    input wire logic dma_last_i,
    output logic dma_take_o,
    output logic dma_done_o,
    output logic [31:0] dma_rdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic wait_en_i,
    input wire logic [WAIT_W-1:0] wait_count_i,
    input wire logic sw_reset_i,
    input wire logic shutdown_det_en_i,
    input wire logic irq_pending_i,
    output logic slave_sel_o,
    output lbh_cyc_t slave_cyc_o,
    output logic [31:0] slave_addr_o,
    output logic [3:0] slave_lanes_n_o,
    output logic slave_pipe_o,
    output logic [2:0] encoded_dma_ack_o,
    output logic end_of_process_n_o,
    output logic phase_two_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic phase;                        // High on the second clock of a bus state.
        logic rst_seen;                     // Reset seen; phase realigns on release.
        lbh_mst_t mst;                      // Master bus state.
        logic master;                       // Device owns the bus.
        logic [31:0] addr;                  // Driven address.
        logic [3:0] lanes_n;                // Driven byte lanes.
        logic [2:0] cyc;                    // Driven cycle type.
        logic [31:0] wdata;                 // Write data.
        logic last;                         // Current master cycle ends the process.
        logic wr;                           // Current master cycle is a write.
        logic [31:0] rdata;                 // Captured read data.
        logic done;                         // One-cycle pulse: master cycle ended.
        logic slv_busy;                     // Host cycle in progress.
        logic prev_ads_n;                   // Strobe seen on previous bus state.
        logic prev_rdy_n;                   // Done seen on previous bus state.
        logic pipe;                         // Current slave cycle was pipelined.
        lbh_cyc_t scyc;                     // Decoded slave cycle.
        logic [31:0] saddr;                 // Latched slave address.
        logic [3:0] slanes_n;               // Latched slave lanes.
        logic sel;                          // Slave cycle under decode.
        logic [WAIT_W:0] wcnt;              // Wait states left.
        logic rdy_n;                        // Ready answer to host.
        logic rd_drive;                     // Driving read data.
        logic [`LBH_HOST_CPU_RESET_OUT_W-1:0] crst_cnt; // CPU reset periods left.
        logic crst;                         // CPU reset level.
    } lbh_dev_st_t;

    lbh_dev_st_t st_q;
    lbh_dev_st_t st_d;

    // Decode of host cycle type and lanes.
    function automatic lbh_cyc_t decode_cyc(input logic [2:0] c, input logic [3:0] ln);
        case (c)
            `LBH_CYC_INTA: decode_cyc = LBH_C_INTA;
            `LBH_CYC_IOR: decode_cyc = LBH_C_IOR;
            `LBH_CYC_IOW: decode_cyc = LBH_C_IOW;
            `LBH_CYC_MEMR: decode_cyc = LBH_C_MEMR;
            `LBH_CYC_MEMW: decode_cyc = LBH_C_MEMW;
            `LBH_CYC_HALT_SD: begin
                if ((ln & `LBH_LANE_HALT_MASK) == `LBH_LANE_HALT_VAL) begin
                    decode_cyc = LBH_C_HALT;
                end else if (!ln[0]) begin
                    decode_cyc = LBH_C_SHUTDOWN;
                end else begin
                    decode_cyc = LBH_C_NONE;
                end
            end
            default: decode_cyc = LBH_C_NONE;
        endcase
    endfunction

    // Force the data/control bit high and only legal I/O or memory types.
    function automatic logic [2:0] legal_cyc(input logic [2:0] c);
        legal_cyc = {c[2], 1'b1, c[0]};
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic edge2;
        logic ads_n;
        logic rdy_n;
        logic na_n;
        logic launch;
        lbh_cyc_t dc;
        edge2 = 1'b0;
        ads_n = 1'b1;
        rdy_n = 1'b1;
        na_n = 1'b1;
        launch = 1'b0;
        dc = LBH_C_NONE;
        st_d = st_q;
        st_d.done = 1'b0;
        // Phase toggles each clock; the first clock after release is phase one.
        st_d.phase = ~st_q.phase;
        if (st_q.rst_seen) begin
            st_d.phase = 1'b0;
            st_d.rst_seen = 1'b0;
        end
        edge2 = st_q.phase; // End of a bus state.
        ads_n = bus.addr_strobe_n;
        rdy_n = bus.cycle_done_n;
        na_n = st_q.master ? bus.next_addr_req_n : 1'b1;
        // CPU reset pulse countdown.
        if (st_q.crst_cnt != '0) begin
            st_d.crst_cnt = st_q.crst_cnt - 1'b1;
        end
        st_d.crst = (st_d.crst_cnt != '0);
        if (edge2) begin
            st_d.prev_ads_n = ads_n;
            st_d.prev_rdy_n = rdy_n;
            if (!st_q.master) begin
                // Slave side: new host cycle when strobe low; valid type then.
                if (!ads_n) begin
                    dc = decode_cyc(bus.cyc_type, bus.byte_lane_sel_n);
                    st_d.scyc = dc;
                    st_d.saddr = bus.addr;
                    st_d.slanes_n = bus.byte_lane_sel_n;
                    // Strobe while previous cycle still open means pipelined.
                    st_d.pipe = st_q.slv_busy && rdy_n;
                    st_d.slv_busy = 1'b1;
                    st_d.sel = 1'b1; // Pipelined decode starts a state earlier.
                    st_d.wcnt = wait_en_i ? ({1'b0, wait_count_i} + {{WAIT_W{1'b0}}, ~st_d.pipe}) : '0;
                    if (dc == LBH_C_SHUTDOWN && shutdown_det_en_i) begin
                        st_d.crst_cnt = `LBH_HOST_CPU_RESET_OUT_W'(`LBH_HOST_CPU_RESET_OUT_PERIODS);
                        st_d.crst = 1'b1;
                    end
                end else if (st_q.slv_busy && !rdy_n) begin
                    st_d.slv_busy = 1'b0;
                    st_d.sel = 1'b0;
                end
                if (st_q.sel && st_q.wcnt != '0) begin
                    st_d.wcnt = st_q.wcnt - 1'b1;
                end
                // Grant moves the device to master.
                if (bus.bus_grant_in && dma_req_i && !st_q.slv_busy) begin
                    st_d.master = 1'b1;
                    st_d.mst = LBH_S_IDLE;
                end
            end else begin
                launch = dma_req_i && bus.bus_grant_in;
                case (st_q.mst)
                    LBH_S_IDLE: begin
                        if (!bus.bus_grant_in || !dma_req_i) begin
                            st_d.master = 1'b0;
                        end else begin
                            st_d.mst = LBH_S_T1;
                        end
                    end
                    LBH_S_T1, LBH_S_T1P: begin
                        // At least one more state follows T1.
                        st_d.mst = (!na_n && launch) ? LBH_S_T2P : LBH_S_T2;
                    end
                    LBH_S_T2, LBH_S_T2P, LBH_S_T2I: begin
                        if (!rdy_n) begin
                            st_d.done = 1'b1;
                            st_d.rdata = bus.data;
                            if (st_q.mst == LBH_S_T2P) begin
                                st_d.mst = LBH_S_T1P;
                            end else if (launch && !st_q.last) begin
                                st_d.mst = LBH_S_T1;
                            end else begin
                                st_d.mst = LBH_S_IDLE;
                            end
                        end else if (!na_n && launch && st_q.mst != LBH_S_T2P) begin
                            st_d.mst = LBH_S_T2P;
                        end else if (!na_n && st_q.mst != LBH_S_T2P) begin
                            st_d.mst = LBH_S_T2I;
                        end
                    end
                    default: st_d.mst = LBH_S_IDLE;
                endcase
                // Load the next address when a new first state begins.
                if ((st_d.mst == LBH_S_T1 || st_d.mst == LBH_S_T2P) && st_q.mst != LBH_S_T2P) begin
                    st_d.addr = dma_addr_i;
                    st_d.lanes_n = dma_lanes_n_i;
                    st_d.cyc = legal_cyc(dma_cyc_i);
                    st_d.wdata = dma_wdata_i;
                    st_d.last = dma_last_i;
                    st_d.wr = dma_cyc_i[0];
                end
                if (!bus.bus_grant_in && st_d.mst == LBH_S_IDLE) begin
                    st_d.master = 1'b0;
                end
            end
        end
        st_d.rdy_n = !(st_d.sel && st_d.wcnt == '0);
        st_d.rd_drive = st_d.sel && !st_d.master &&
                        (st_d.scyc == LBH_C_IOR || st_d.scyc == LBH_C_INTA);
        if (sw_reset_i) begin
            st_d.crst_cnt = `LBH_HOST_CPU_RESET_OUT_W'(`LBH_HOST_CPU_RESET_OUT_PERIODS);
            st_d.crst = 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset aborts everything and returns to slave with bus released.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.rst_seen <= 1'b1;
            st_q.mst <= LBH_S_IDLE;
            st_q.scyc <= LBH_C_NONE;
            st_q.prev_ads_n <= 1'b1;
            st_q.prev_rdy_n <= 1'b1;
            st_q.rdy_n <= 1'b1;
            st_q.lanes_n <= 4'hF;
            st_q.crst_cnt <= `LBH_HOST_CPU_RESET_OUT_W'(`LBH_HOST_CPU_RESET_OUT_PERIODS);
            st_q.crst <= 1'b1; // Pulse stands from reset into the countdown, with no gap at release.
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Strobe only in first and pipelined states; released otherwise.
    assign bus.addr_strobe_n_dev = 1'b0;
    assign bus.addr_strobe_n_dev_oe = st_q.master && (st_q.mst == LBH_S_T1 || st_q.mst == LBH_S_T2P);
    assign bus.addr_dev = st_q.addr;
    assign bus.byte_lane_sel_n_dev = st_q.lanes_n;
    assign bus.addr_dev_oe = st_q.master && st_q.mst != LBH_S_IDLE;
    assign bus.cyc_type_dev = st_q.cyc;
    assign bus.cyc_dev_oe = bus.addr_dev_oe;
    // Read byte copied to all four lanes.
    assign bus.data_dev = st_q.rd_drive ? {4{reg_rdata_i}} : st_q.wdata;
    assign bus.data_dev_oe = st_q.rd_drive || (bus.addr_dev_oe && st_q.wr);
    assign bus.bus_request = dma_req_i && !st_q.rst_seen;
    assign bus.host_cpu_reset_out = st_q.crst || !rst_n_i;
    assign bus.irq_out = irq_pending_i;
    assign bus.wait_gen_done_n = st_q.rdy_n;
    assign dma_take_o = bus.addr_strobe_n_dev_oe;
    assign dma_done_o = st_q.done;
    assign dma_rdata_o = st_q.rdata;
    assign slave_sel_o = st_q.sel;
    assign slave_cyc_o = st_q.scyc;
    assign slave_addr_o = st_q.saddr;
    assign slave_lanes_n_o = st_q.slanes_n;
    assign slave_pipe_o = st_q.pipe;
    assign encoded_dma_ack_o = `LBH_EDACK_IDLE;
    assign end_of_process_n_o = 1'b1;
    assign phase_two_o = st_q.phase;
endmodule

// [core/lbh_host_end.sv]
// Host end of the local bus: issues cycles in slave mode and grants the bus.
`timescale 1ns/1ps
`include "lbh_consts.svh"

module lbh_host_end
    import lbh_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    lbh_bus_if.host bus,
    input wire logic req_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [3:0] req_lanes_n_i,
    input wire logic [2:0] req_cyc_i,
    input wire logic [31:0] req_wdata_i,
    input wire logic grant_en_i,
    output logic req_ready_o,
    output logic resp_valid_o,
    output logic [31:0] resp_data_o,
    output logic cpu_in_reset_o,
    output logic irq_seen_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic phase;         // Second clock of a bus state.
        logic busy;          // Cycle outstanding.
        logic strobe;        // Driving strobe this state.
        logic [31:0] addr;   // Address driven.
        logic [3:0] lanes_n; // Lanes driven.
        logic [2:0] cyc;     // Cycle type driven.
        logic [31:0] wdata;  // Write data.
        logic grant;         // Bus handed to the device.
        logic rv;            // Response pulse.
        logic [31:0] rdata;  // Response data.
    } lbh_host_st_t;

    lbh_host_st_t st_q;
    lbh_host_st_t st_d;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.rv = 1'b0;
        st_d.phase = ~st_q.phase;
        // A CPU reset parks the phase high; the host wakes in step with the device's bus states after power-on reset, a clock out of step after a shutdown reset.
        if (bus.host_cpu_reset_out) begin
            st_d.phase = 1'b1;
        end
        if (st_q.phase) begin
            st_d.strobe = 1'b0;
            // Cycle ends on done low, at least two states long.
            if (st_q.busy && !st_q.strobe && !bus.cycle_done_n) begin
                st_d.busy = 1'b0;
                st_d.rv = 1'b1;
                st_d.rdata = bus.data;
            end
            if (!st_q.busy && !st_q.grant && req_i) begin
                st_d.busy = 1'b1;
                st_d.strobe = 1'b1;
                st_d.addr = req_addr_i;
                st_d.lanes_n = req_lanes_n_i;
                st_d.cyc = req_cyc_i;
                st_d.wdata = req_wdata_i;
            end
            // Grant only between cycles.
            st_d.grant = bus.bus_request && grant_en_i && !st_d.busy;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.lanes_n <= 4'hF;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus.addr_host = st_q.addr;
    assign bus.byte_lane_sel_n_host = st_q.lanes_n;
    assign bus.addr_host_oe = st_q.busy;
    assign bus.cyc_type_host = st_q.cyc;
    assign bus.cyc_host_oe = st_q.busy;
    assign bus.addr_strobe_n_host = 1'b0;
    assign bus.addr_strobe_n_host_oe = st_q.strobe;
    assign bus.data_host = st_q.wdata;
    assign bus.data_host_oe = st_q.busy && st_q.cyc[0];
    assign bus.bus_grant_in = st_q.grant;
    assign req_ready_o = st_q.phase && !st_q.busy && !st_q.grant;
    assign resp_valid_o = st_q.rv;
    assign resp_data_o = st_q.rdata;
    assign cpu_in_reset_o = bus.host_cpu_reset_out;
    assign irq_seen_o = bus.irq_out;
endmodule

// [sim/lbh_bus_monitor.sv]
// Concurrent checks on the shared local bus between the two ends.
`timescale 1ns/1ps
module lbh_bus_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic addr_dev_oe,
    input wire logic data_dev_oe,
    input wire logic cyc_dev_oe,
    input wire logic [2:0] cyc_type_dev,
    input wire logic addr_strobe_n_dev,
    input wire logic addr_strobe_n_dev_oe,
    input wire logic addr_strobe_n,
    input wire logic cyc_host_oe,
    input wire logic bus_request,
    input wire logic bus_grant_in,
    input wire logic wait_gen_done_n,
    input wire logic host_cpu_reset_out
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic quiet_q; // Device bus outputs were idle at the previous edge.
    logic [7:0] rst_len_q; // Edges seen with the CPU reset high.
    logic dev_strb; // Device drives the strobe low.
    assign dev_strb = addr_strobe_n_dev_oe && !addr_strobe_n_dev;
    // Counts the length of each CPU reset pulse.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_len_q <= 8'h00;
        end else begin
            rst_len_q <= host_cpu_reset_out ? rst_len_q + 8'h01 : 8'h00;
        end
    end
    // Remembers whether the device kept off the bus.
    always_ff @(posedge sys_clk_i) begin
        quiet_q <= !(addr_dev_oe || data_dev_oe || cyc_dev_oe || addr_strobe_n_dev_oe || bus_request) && wait_gen_done_n;
    end
    AST_RST_QUIET: assert property ($rose(rst_n_i) |-> quiet_q && host_cpu_reset_out)
        else $error("device outputs active in reset");
    AST_HOST_CPU_RESET_OUT_LEN: assert property ($fell(host_cpu_reset_out) |-> rst_len_q == 8'h3E)
        else $error("cpu reset pulse length wrong");
    AST_HOST_CPU_RESET_OUT_MAX: assert property (rst_len_q <= 8'h3E)
        else $error("cpu reset pulse too long");
    AST_MST_TYPE: assert property (cyc_dev_oe |-> cyc_type_dev[1])
        else $error("master cycle with control type");
    AST_CYC_VALID: assert property (!addr_strobe_n |-> cyc_dev_oe || cyc_host_oe)
        else $error("strobe low without cycle type");
    AST_MST_STROBE: assert property ($changed(dev_strb) |=> $stable(dev_strb))
        else $error("master strobe changed inside a bus state");
    AST_IDLE_FLOAT: assert property (addr_strobe_n_dev_oe |-> addr_dev_oe)
        else $error("strobe driven outside a cycle");
    AST_GRANT_FIRST: assert property ($rose(addr_dev_oe) |-> bus_grant_in && bus_request)
        else $error("master without grant");
    AST_CYC_MIN: assert property ($rose(dev_strb) |-> addr_dev_oe [*4])
        else $error("master cycle shorter than two states");
endmodule

// [sim/tb_local_bus_host_interface.sv]
// Self-checking bench joining both ends of the local bus.
`timescale 1ns/1ps
module tb_local_bus_host_interface;
    import lbh_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rdy_n = 1'b1, na_n = 1'b1, dma_req = 1'b0, dma_last = 1'b0, sw_rst = 1'b0;
    logic wait_en = 1'b0, sd_en = 1'b0, irq_pend = 1'b0, req = 1'b0, grant_en = 1'b0, wr = 1'b0;
    logic [31:0] dma_addr = 32'h0, req_addr = 32'h0, rnd = 32'h0;
    logic [3:0] req_ln = 4'hF, wcnt = 4'h0;
    logic [2:0] dma_cyc = 3'h6, req_cyc = 3'h0, edack;
    logic [7:0] reg_rd = 8'h00;
    logic dma_done, ssel, req_rdy, resp_v, irq_seen, eop_n, spipe;
    logic [31:0] resp_d, saddr;
    lbh_cyc_t scyc, seen;
    int seed = 32'h73a52c47, mismatches = 0, check_count = 0, k, n;
    logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    lbh_bus_if bus ();
    assign bus.cycle_done_n = rdy_n;
    assign bus.next_addr_req_n = na_n;
    lbh_dev_end i_lbh_dev_end (.sys_clk_i(clk), .rst_n_i(rst_n), .bus(bus), .dma_req_i(dma_req),
        .dma_addr_i(dma_addr), .dma_lanes_n_i(rnd[7:4]), .dma_cyc_i(dma_cyc), .dma_wdata_i(rnd),
        .dma_last_i(dma_last), .dma_take_o(), .dma_done_o(dma_done), .dma_rdata_o(), .reg_rdata_i(reg_rd),
        .wait_en_i(wait_en), .wait_count_i(wcnt), .sw_reset_i(sw_rst), .shutdown_det_en_i(sd_en),
        .irq_pending_i(irq_pend), .slave_sel_o(ssel), .slave_cyc_o(scyc), .slave_addr_o(saddr), .slave_lanes_n_o(),
        .slave_pipe_o(spipe), .encoded_dma_ack_o(edack), .end_of_process_n_o(eop_n), .phase_two_o());
    lbh_host_end i_lbh_host_end (.sys_clk_i(clk), .rst_n_i(rst_n), .bus(bus), .req_i(req),
        .req_addr_i(req_addr), .req_lanes_n_i(req_ln), .req_cyc_i(req_cyc), .req_wdata_i(~rnd),
        .grant_en_i(grant_en), .req_ready_o(req_rdy), .resp_valid_o(resp_v), .resp_data_o(resp_d),
        .cpu_in_reset_o(), .irq_seen_o(irq_seen));
    lbh_bus_monitor i_lbh_bus_monitor (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_dev_oe(bus.addr_dev_oe),
        .data_dev_oe(bus.data_dev_oe), .cyc_dev_oe(bus.cyc_dev_oe), .cyc_type_dev(bus.cyc_type_dev),
        .addr_strobe_n_dev(bus.addr_strobe_n_dev), .addr_strobe_n_dev_oe(bus.addr_strobe_n_dev_oe),
        .addr_strobe_n(bus.addr_strobe_n), .cyc_host_oe(bus.cyc_host_oe), .bus_request(bus.bus_request),
        .bus_grant_in(bus.bus_grant_in), .wait_gen_done_n(bus.wait_gen_done_n),
        .host_cpu_reset_out(bus.host_cpu_reset_out));
    // Clock of 20 ns and the one random source, read only through registered copies.
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        rnd <= $random(seed);
        rdy_n <= rnd[0];
        na_n <= rnd[1];
    end
    // Remembers the last decoded slave cycle.
    always @(posedge clk) begin
        if (ssel === 1'b1) seen <= scyc;
    end
    // Expected slave decode of a cycle type and lane pattern.
    function automatic lbh_cyc_t exp_cyc(input logic [2:0] c, input logic [3:0] ln);
        case (c)
            3'h0: return LBH_C_INTA;
            3'h2: return LBH_C_IOR;
            3'h3: return LBH_C_IOW;
            3'h5: return ((ln & 4'h7) == 4'h3) ? LBH_C_HALT : (ln[0] ? LBH_C_NONE : LBH_C_SHUTDOWN);
            3'h6: return LBH_C_MEMR;
            default: return LBH_C_MEMW;
        endcase
    endfunction
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic hang(input int cnt);
        if (cnt >= 200) begin
            mismatches++;
            summarize();
        end
    endtask
    // Counts the clock periods that the CPU reset stays high within a fixed window.
    task automatic host_cpu_reset_out_len();
        n = 0;
        repeat (300) begin
            @(negedge clk);
            if (bus.host_cpu_reset_out === 1'b1) n++;
        end
        chk(n == 62, "cpu reset length");
    endtask
    // One host cycle, held until taken; waits for the answer unless told not to.
    task automatic host_cycle(input logic [2:0] c, input logic [3:0] ln, input bit wait_resp);
        @(posedge clk);
        req <= 1'b1;
        req_cyc <= c;
        req_ln <= ln;
        req_addr <= rnd;
        reg_rd <= rnd[15:8];
        k = 0;
        do @(negedge clk); while (req_rdy !== 1'b1 && ++k < 200);
        hang(k);
        @(posedge clk);
        req <= 1'b0;
        k = 0;
        if (wait_resp) do @(negedge clk); while (resp_v !== 1'b1 && ++k < 200);
        hang(k);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        chk(bus.bus_request === 1'b0 && bus.wait_gen_done_n === 1'b1 && edack === 3'h4 && eop_n === 1'b1 &&
            bus.host_cpu_reset_out === 1'b1, "reset levels");
        rst_n <= 1'b1;
        host_cpu_reset_out_len();
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            wait_en <= rnd[2];
            wcnt <= rnd[7:4];
            irq_pend <= rnd[3];
            wr = (codes[i % 6] == 3'h5) ? rnd[8] : 1'b0;
            host_cycle(codes[i % 6], wr ? 4'hB : (codes[i % 6] == 3'h5 ? 4'h6 : rnd[11:8]), 1'b1);
            chk(seen === exp_cyc(req_cyc, req_ln), "slave decode");
            chk(saddr === req_addr && spipe === 1'b0, "slave address");
            if (req_cyc == 3'h2) chk(resp_d === {4{reg_rd}}, "read byte lanes");
            chk(bus.irq_out === irq_pend && irq_seen === irq_pend, "interrupt out");
        end
        $display("test slave done");
        @(posedge clk);
        grant_en <= 1'b1;
        dma_req <= 1'b1;
        dma_addr <= rnd;
        dma_cyc <= rnd[2:0];
        n = 0;
        repeat (300) begin
            @(negedge clk);
            if (dma_done === 1'b1) n++;
            if (bus.addr_strobe_n === 1'b0) chk(bus.addr === dma_addr, "master address");
        end
        chk(n > 0, "master cycles ended");
        @(posedge clk);
        dma_last <= 1'b1;
        dma_req <= 1'b0;
        grant_en <= 1'b0;
        repeat (40) @(posedge clk);
        chk(bus.addr_dev_oe === 1'b0 && bus.bus_request === 1'b0, "bus released");
        $display("test master done");
        sw_rst <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        host_cpu_reset_out_len();
        @(posedge clk);
        sd_en <= 1'b1;
        fork
            host_cycle(3'h5, 4'hE, 1'b0);
            host_cpu_reset_out_len();
        join
        $display("test cpu reset done");
        summarize();
    end
endmodule
